// File: pkg/func_cfg_defines.svh
// Offsets, field positions, reset values and limits of the function configuration bank
`ifndef FUNC_CFG_DEFINES_SVH
`define FUNC_CFG_DEFINES_SVH
`define NUM_PF 4
`define NUM_BAR 6
`define NUM_VF_POOL 252
`define FIRST_VF_FN 8'h04
`define LAST_FN 9'h0FF
`define FN_SPACE 9'h100
`define VF_OFS_LOW 8'h04
`define VF_OFS_HIGH 8'h40
`define VF_OFS_NOARI 8'h01
`define NOARI_MAX_VF 8'h07
`define REV_RST 8'h00
`define BAR_MIN_LOG2 6'h07
`define BAR_LEG_MIN_LOG2 6'h04
`define BAR32_MAX_LOG2 6'h1F
`define BAR64_MAX_LOG2 6'h3F
`define ROM_MIN_LOG2 6'h0B
`define ROM_MAX_LOG2 6'h20
`define ROM_REC_LOG2 6'h18
`define RP_MAX_BARS 3'h2
// Register word index layout: bits [9:8] select the function
`define ADDR_W 10
`define OFS_REVCLASS 8'h00
`define OFS_BAR0 8'h04
`define OFS_ROM 8'h0C
`define OFS_SRIOV 8'h10
`define OFS_VFCNT 8'h11
`define OFS_VFOFS 8'h12
`define OFS_BARCFG0 8'h20
`define OFS_ROMCFG 8'h30
`define OFS_GLOBAL 8'hF0
`define OFS_MAP 8'hF1
`define OFS_STATUS 8'hF2
`define BAR_IO_BIT 0
`define BAR_64_BIT 2
`define BAR_PF_BIT 3
`define ROM_EN_BIT 0
`define ALL_ONES 32'hFFFFFFFF
`endif

// File: pkg/func_cfg_pkg.sv
// Types shared by the function configuration bank
package func_cfg_pkg;
    typedef struct packed {
        logic en;
        logic io;
        logic is64;
        logic pref;
        logic [5:0] size_log2;
    } bar_cfg_type;

    typedef struct packed {
        logic [7:0] rev;
        logic [7:0] base_class;
        logic [7:0] sub_class;
        logic [7:0] prog_if;
    } ident_type;

    typedef struct packed {
        logic [3:0] cap_ver;
        logic [7:0] dep_link;
    } sriov_type;

    typedef enum logic [1:0] {
        MODE_EP = 2'b00,
        MODE_LEGACY = 2'b01,
        MODE_RP = 2'b11
    } port_mode_type;

    typedef enum logic [1:0] {
        LKP_IDLE = 2'b00,
        LKP_SCAN = 2'b01,
        LKP_DONE = 2'b11
    } lkp_state_type;
endpackage : func_cfg_pkg

// File: hw/bar_decode.sv
// One BAR: legality, all-ones sizing mask and space-typed address hit
`timescale 1ns/10ps
`include "func_cfg_defines.svh"
module bar_decode
    import func_cfg_pkg::*;
(
    input wire bar_cfg_type i_cfg, // Configured attributes
    input wire port_mode_type i_mode, // Port mode
    input wire logic i_last, // Highest BAR slot
    input wire logic i_hidden, // Upper half of a 64-bit pair
    input wire logic [31:0] i_base, // Programmed base
    input wire logic [31:0] i_addr, // Request address
    input wire logic i_is_io, // Request is I/O space
    output logic o_legal, // Attributes allowed
    output logic [31:0] o_mask, // Sizing answer
    output logic o_hit // Request claimed
);
    logic [5:0] min_l2;
    logic [5:0] max_l2;
    logic [31:0] amask;
    logic [5:0] sz;
    always_comb begin
        min_l2 = (i_mode == MODE_LEGACY) ? `BAR_LEG_MIN_LOG2 : `BAR_MIN_LOG2;
        max_l2 = i_cfg.is64 ? `BAR64_MAX_LOG2 : `BAR32_MAX_LOG2;
        o_legal = (i_cfg.size_log2 >= min_l2) && (i_cfg.size_log2 <= max_l2);
        if (i_cfg.io && (i_cfg.is64 || i_cfg.pref || i_mode != MODE_LEGACY)) begin
            o_legal = 1'b0;
        end
        if (i_mode == MODE_EP && i_cfg.pref && !i_cfg.is64 && !i_last) begin
            o_legal = 1'b0;
        end
        if (i_cfg.is64 && i_last) begin
            o_legal = 1'b0;
        end
        sz = (i_cfg.size_log2 > 6'h20) ? 6'h20 : i_cfg.size_log2;
        amask = (sz == 6'h20) ? 32'h00000000 : (`ALL_ONES << sz);
        o_mask = 32'h00000000;
        if (i_cfg.en && o_legal && !i_hidden) begin
            o_mask = amask;
            o_mask[`BAR_IO_BIT] = i_cfg.io;
            o_mask[`BAR_64_BIT] = i_cfg.is64 && !i_cfg.io;
            o_mask[`BAR_PF_BIT] = i_cfg.pref && !i_cfg.io;
        end
        o_hit = i_cfg.en && o_legal && !i_hidden && (i_is_io == i_cfg.io)
            && ((i_addr & amask) == (i_base & amask));
    end
endmodule : bar_decode

// File: hw/func_cfg_bank.sv
// Function configuration bank: identity, BARs, expansion ROM and SR-IOV function map
// Operation
// - Revision field, default zero, configurable
// - Class code as three byte fields
// - Endpoint: six 32-bit or three 64-bit BARs
// - Root port: two 32-bit or one 64-bit
// - 64-bit BAR hides following BAR
// - I/O BAR: 32-bit, unprefetchable, legacy only
// - 32-bit aperture 128 bytes to 2 GB
// - 64-bit aperture memory, 128 B to 8 EB
// - Legacy I/O aperture 16 B to 2 GB
// - ROM aperture 2 KB to 4 GB
// - BAR claims only its own space type
// - Endpoint prefetchable BARs except last are 64-bit
// - Minimum aperture 128 B, legacy 16 B
// - Each BAR enabled individually; disabled decodes nothing
// - ARI: offset 4 or 64, sum within 256
// - No ARI: offset 1, one PF seven VFs
// - Per-PF 4-bit SR-IOV capability version
// - Pool of 252 VFs across four PFs
// - PF function number equals its index
// - VF function numbers 4 through 255
// - Offset accepted only if last VF within 255
// - Per-PF SR-IOV dependency link field
// - Four PFs, each with own settings
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "func_cfg_defines.svh"
module func_cfg_bank
    import func_cfg_pkg::*;
#(
    parameter int NUM_PF = `NUM_PF,
    parameter int VF_POOL = `NUM_VF_POOL,
    parameter logic [7:0] REV_DEFAULT = `REV_RST
)(
    input wire logic i_mclk, // 100 MHz clock
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic [`ADDR_W-1:0] i_addr, // Register word index
    input wire logic [31:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [31:0] o_rdata, // Read data, cycle after strobe
    input wire logic [31:0] i_req_addr, // Request address to decode
    input wire logic i_req_io, // Request targets I/O space
    input wire logic i_req_valid, // Request present
    output logic o_req_hit, // Some BAR or ROM claimed it
    output logic [1:0] o_req_pf, // Claiming function
    output logic [2:0] o_req_bar, // Claiming BAR, 6 means ROM
    output logic o_cfg_ok, // Whole configuration legal
    output logic o_map_busy // Function map being rebuilt
);
    // Per-function and global state
    ident_type ident_ff [NUM_PF], nxt_ident [NUM_PF];
    sriov_type sriov_ff [NUM_PF], nxt_sriov [NUM_PF];
    bar_cfg_type barcfg_ff [NUM_PF][`NUM_BAR], nxt_barcfg [NUM_PF][`NUM_BAR];
    logic [31:0] base_ff [NUM_PF][`NUM_BAR], nxt_base [NUM_PF][`NUM_BAR];
    logic [31:0] rom_base_ff [NUM_PF], nxt_rom_base [NUM_PF];
    logic [6:0] rom_cfg_ff [NUM_PF], nxt_rom_cfg [NUM_PF];
    logic [7:0] vfcnt_ff [NUM_PF], nxt_vfcnt [NUM_PF];
    port_mode_type mode_ff, nxt_mode;
    logic ari_ff, nxt_ari;
    logic [7:0] first_ofs_ff, nxt_first_ofs;
    logic [31:0] rdata_ff, nxt_rdata;
    // Map walker
    lkp_state_type st_ff, nxt_st;
    logic [1:0] scan_ff, nxt_scan;
    logic [8:0] acc_ff, nxt_acc;
    logic [7:0] pf_ofs_ff [NUM_PF], nxt_pf_ofs [NUM_PF];
    logic map_ok_ff, nxt_map_ok;

    logic [31:0] mask_w [NUM_PF][`NUM_BAR];
    logic hit_w [NUM_PF][`NUM_BAR];
    logic legal_w [NUM_PF][`NUM_BAR];
    logic [1:0] fn;
    logic [7:0] ofs;
    logic [9:0] vf_total;
    logic [8:0] eff_ofs;
    logic bars_ok;
    logic rom_ok;
    logic sum_ok;
    logic cfg_wr;

    function automatic logic [5:0] bar_slot_limit(input port_mode_type m);
        bar_slot_limit = (m == MODE_RP) ? {3'h0, `RP_MAX_BARS} : 6'(`NUM_BAR);
    endfunction : bar_slot_limit

    function automatic logic [31:0] rom_mask(input logic [6:0] c);
        logic [5:0] s;
        s = c[6:1];
        rom_mask = 32'h00000000;
        if (c[`ROM_EN_BIT] && s >= `ROM_MIN_LOG2 && s <= `ROM_MAX_LOG2) begin
            rom_mask = (s == 6'h20) ? 32'h00000000 : (`ALL_ONES << s);
            rom_mask[`ROM_EN_BIT] = 1'b1;
        end
    endfunction : rom_mask

    assign fn = i_addr[9:8];
    assign ofs = i_addr[7:0];
    assign cfg_wr = i_wr && (st_ff == LKP_IDLE || ofs != `OFS_VFCNT);

    genvar gp, gb;
    generate
        for (gp = 0; gp < NUM_PF; gp++) begin : g_pf
            for (gb = 0; gb < `NUM_BAR; gb++) begin : g_bar
                logic hidden;
                logic over;
                if (gb == 0) begin : g_first
                    assign hidden = 1'b0;
                end else begin : g_rest
                    assign hidden = barcfg_ff[gp][gb-1].is64 && barcfg_ff[gp][gb-1].en;
                end
                assign over = 6'(gb) >= bar_slot_limit(mode_ff);
                bar_decode u_bar (
                    .i_cfg(barcfg_ff[gp][gb]),
                    .i_mode(mode_ff),
                    .i_last(gb == `NUM_BAR - 1 || (mode_ff == MODE_RP && gb == `RP_MAX_BARS - 1)),
                    .i_hidden(hidden || over),
                    .i_base(base_ff[gp][gb]),
                    .i_addr(i_req_addr),
                    .i_is_io(i_req_io),
                    .o_legal(legal_w[gp][gb]),
                    .o_mask(mask_w[gp][gb]),
                    .o_hit(hit_w[gp][gb])
                );
            end
        end
    endgenerate

    // Register writes and read mux
    always_comb begin
        nxt_ident = ident_ff;
        nxt_sriov = sriov_ff;
        nxt_barcfg = barcfg_ff;
        nxt_base = base_ff;
        nxt_rom_base = rom_base_ff;
        nxt_rom_cfg = rom_cfg_ff;
        nxt_vfcnt = vfcnt_ff;
        nxt_mode = mode_ff;
        nxt_ari = ari_ff;
        nxt_first_ofs = first_ofs_ff;
        nxt_rdata = 32'h00000000;
        if (cfg_wr) begin
            case (ofs)
                `OFS_REVCLASS: nxt_ident[fn] = i_wdata;
                `OFS_SRIOV: nxt_sriov[fn] = {i_wdata[3:0], i_wdata[15:8]};
                `OFS_VFCNT: nxt_vfcnt[fn] = i_wdata[7:0];
                `OFS_ROM: nxt_rom_base[fn] = i_wdata & rom_mask(rom_cfg_ff[fn]);
                `OFS_ROMCFG: nxt_rom_cfg[fn] = i_wdata[6:0];
                `OFS_GLOBAL: begin
                    nxt_mode = port_mode_type'(i_wdata[1:0]);
                    nxt_ari = i_wdata[4];
                    nxt_first_ofs = i_wdata[15:8];
                end
                default: begin
                    for (int b = 0; b < `NUM_BAR; b++) begin
                        if (ofs == `OFS_BAR0 + 8'(b)) begin
                            // Base keeps only the decoded bits, so all-ones reads back the size
                            nxt_base[fn][b] = i_wdata & {mask_w[fn][b][31:4], 4'h0};
                        end
                        if (ofs == `OFS_BARCFG0 + 8'(b)) begin
                            nxt_barcfg[fn][b] = i_wdata[9:0];
                        end
                    end
                end
            endcase
        end
        if (i_rd) begin
            case (ofs)
                `OFS_REVCLASS: nxt_rdata = ident_ff[fn];
                `OFS_SRIOV: nxt_rdata = {16'h0000, sriov_ff[fn].dep_link, 4'h0, sriov_ff[fn].cap_ver};
                `OFS_VFCNT: nxt_rdata = {24'h000000, vfcnt_ff[fn]};
                `OFS_VFOFS: nxt_rdata = {24'h000000, pf_ofs_ff[fn]};
                `OFS_ROM: nxt_rdata = rom_base_ff[fn] | (rom_mask(rom_cfg_ff[fn]) & 32'h00000001);
                `OFS_ROMCFG: nxt_rdata = {25'h0, rom_cfg_ff[fn]};
                `OFS_GLOBAL: nxt_rdata = {16'h0000, eff_ofs[7:0], 3'h0, ari_ff, 2'h0, mode_ff};
                `OFS_MAP: nxt_rdata = {22'h0, vf_total};
                `OFS_STATUS: nxt_rdata = {28'h0, rom_ok, sum_ok, map_ok_ff, bars_ok};
                default: begin
                    for (int b = 0; b < `NUM_BAR; b++) begin
                        if (ofs == `OFS_BAR0 + 8'(b)) begin
                            nxt_rdata = base_ff[fn][b] | {28'h0, mask_w[fn][b][3:0]};
                        end
                        if (ofs == `OFS_BARCFG0 + 8'(b)) begin
                            nxt_rdata = {21'h0, legal_w[fn][b], barcfg_ff[fn][b]};
                        end
                    end
                end
            endcase
        end
    end

    // Function map walker: per-PF first VF offset from the global offset and counts
    always_comb begin
        nxt_st = st_ff;
        nxt_scan = scan_ff;
        nxt_acc = acc_ff;
        nxt_pf_ofs = pf_ofs_ff;
        nxt_map_ok = map_ok_ff;
        case (st_ff)
            LKP_IDLE: begin
                if (cfg_wr && (ofs == `OFS_VFCNT || ofs == `OFS_GLOBAL)) begin
                    nxt_st = LKP_SCAN;
                    nxt_scan = 2'h0;
                    nxt_acc = 9'h000;
                    nxt_map_ok = 1'b0;
                end
            end
            LKP_SCAN: begin
                // VFs follow in PF order; offset is relative to the PF's own number
                // Global offset is read here, not at start, so the write that began the walk counts
                nxt_pf_ofs[scan_ff] = 8'(eff_ofs + acc_ff - {7'h0, scan_ff});
                nxt_acc = acc_ff + {1'b0, vfcnt_ff[scan_ff]};
                nxt_scan = scan_ff + 2'h1;
                if (scan_ff == 2'(NUM_PF - 1)) begin
                    nxt_st = LKP_DONE;
                end
            end
            LKP_DONE: begin
                nxt_map_ok = sum_ok;
                nxt_st = LKP_IDLE;
            end
            default: nxt_st = LKP_IDLE;
        endcase
    end

    always_comb begin
        // Wide enough that four full counts cannot wrap into a legal total
        vf_total = 10'h000;
        for (int p = 0; p < NUM_PF; p++) begin
            vf_total = vf_total + {2'b00, vfcnt_ff[p]};
        end
        eff_ofs = ari_ff ? {1'b0, first_ofs_ff} : {1'b0, `VF_OFS_NOARI};
        if (ari_ff) begin
            // Last VF number is offset + total - 1, so the sum may reach 256 exactly
            sum_ok = (first_ofs_ff == `VF_OFS_LOW || first_ofs_ff == `VF_OFS_HIGH)
                && (eff_ofs + vf_total <= `FN_SPACE) && (vf_total <= 10'(VF_POOL));
        end else begin
            sum_ok = (vf_total <= {2'b00, `NOARI_MAX_VF}) && vfcnt_ff[1] == 8'h00
                && vfcnt_ff[2] == 8'h00 && vfcnt_ff[3] == 8'h00;
        end
        bars_ok = 1'b1;
        rom_ok = 1'b1;
        for (int p = 0; p < NUM_PF; p++) begin
            for (int b = 0; b < `NUM_BAR; b++) begin
                if (barcfg_ff[p][b].en && !legal_w[p][b]) begin
                    bars_ok = 1'b0;
                end
            end
            if (rom_cfg_ff[p][`ROM_EN_BIT] && rom_mask(rom_cfg_ff[p]) == 32'h00000000) begin
                rom_ok = 1'b0;
            end
        end
    end

    // Request decode: lowest function and BAR wins
    always_comb begin
        o_req_hit = 1'b0;
        o_req_pf = 2'h0;
        o_req_bar = 3'h0;
        for (int p = NUM_PF - 1; p >= 0; p--) begin
            if (i_req_valid && !i_req_io && rom_mask(rom_cfg_ff[p]) != 32'h00000000
                && (((i_req_addr ^ rom_base_ff[p]) & rom_mask(rom_cfg_ff[p]) & ~32'h00000001) == 32'h00000000)) begin
                o_req_hit = 1'b1;
                o_req_pf = 2'(p);
                o_req_bar = 3'h6;
            end
            for (int b = `NUM_BAR - 1; b >= 0; b--) begin
                if (i_req_valid && hit_w[p][b]) begin
                    o_req_hit = 1'b1;
                    o_req_pf = 2'(p);
                    o_req_bar = 3'(b);
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            for (int p = 0; p < NUM_PF; p++) begin
                ident_ff[p] <= '{rev: REV_DEFAULT, default: 8'h00};
                sriov_ff[p] <= '0;
                base_ff[p] <= '{default: 32'h00000000};
                barcfg_ff[p] <= '{default: bar_cfg_type'(10'h000)};
                rom_base_ff[p] <= 32'h00000000;
                rom_cfg_ff[p] <= 7'h00;
                vfcnt_ff[p] <= 8'h00;
                pf_ofs_ff[p] <= 8'h00;
            end
            mode_ff <= MODE_EP;
            ari_ff <= 1'b0;
            first_ofs_ff <= `VF_OFS_LOW;
            rdata_ff <= 32'h00000000;
            st_ff <= LKP_IDLE;
            scan_ff <= 2'h0;
            acc_ff <= 9'h000;
            map_ok_ff <= 1'b0;
        end else begin
            ident_ff <= nxt_ident;
            sriov_ff <= nxt_sriov;
            base_ff <= nxt_base;
            barcfg_ff <= nxt_barcfg;
            rom_base_ff <= nxt_rom_base;
            rom_cfg_ff <= nxt_rom_cfg;
            vfcnt_ff <= nxt_vfcnt;
            pf_ofs_ff <= nxt_pf_ofs;
            mode_ff <= nxt_mode;
            ari_ff <= nxt_ari;
            first_ofs_ff <= nxt_first_ofs;
            rdata_ff <= nxt_rdata;
            st_ff <= nxt_st;
            scan_ff <= nxt_scan;
            acc_ff <= nxt_acc;
            map_ok_ff <= nxt_map_ok;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_cfg_ok = bars_ok && rom_ok && map_ok_ff;
    assign o_map_busy = st_ff != LKP_IDLE;

    sequence s_map_start;
        cfg_wr && ofs == `OFS_GLOBAL && st_ff == LKP_IDLE;
    endsequence
    sequence s_map_walk;
        (st_ff == LKP_SCAN) [*4] ##1 st_ff == LKP_DONE;
    endsequence

    a_map_walk_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_map_start |=> s_map_walk ##1 !o_map_busy) else $error("map walk length wrong");
    a_pf0_vf_offset: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $fell(o_map_busy) |-> pf_ofs_ff[0] == eff_ofs[7:0]) else $error("pf0 offset wrong");
    a_noari_force: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !ari_ff |-> eff_ofs == 9'h001) else $error("non-ari offset not one");
    a_ari_reject: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ari_ff && first_ofs_ff != `VF_OFS_LOW && first_ofs_ff != `VF_OFS_HIGH |-> !sum_ok)
        else $error("bad ari offset accepted");
    a_last_vf_fit: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        sum_ok && ari_ff |-> eff_ofs + vf_total - 9'h1 <= `LAST_FN) else $error("last vf beyond 255");
    a_rev_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_rd && ofs == `OFS_REVCLASS |=> o_rdata[31:24] == $past(ident_ff[fn].rev))
        else $error("revision read wrong");
    a_hidden_bar: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        barcfg_ff[0][0].en && barcfg_ff[0][0].is64 |-> !hit_w[0][1] && mask_w[0][1] == 32'h0)
        else $error("upper half of pair decodes");
    a_space_type: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        hit_w[0][0] |-> i_req_io == barcfg_ff[0][0].io) else $error("wrong space claimed");
    a_rp_bar_cut: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        mode_ff == MODE_RP |-> !hit_w[0][2] && !hit_w[0][5]) else $error("root port extra bar");
    a_bar_disable: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !barcfg_ff[1][3].en |-> !hit_w[1][3] && mask_w[1][3] == 32'h0) else $error("disabled bar decodes");
endmodule : func_cfg_bank

// File: dv/cfg_requester.sv
// Far-side requester model that presents address decode requests
`timescale 1ns/10ps
module cfg_requester (
    input wire logic i_mclk, // Clock
    input wire logic i_go, // Present a request next cycle
    input wire logic [31:0] i_addr, // Address to present
    input wire logic i_io, // I/O space request
    output logic [31:0] o_req_addr = 32'h00000000, // Request address
    output logic o_req_io = 1'b0, // Request space type
    output logic o_req_valid = 1'b0 // Request present
);
    always_ff @(posedge i_mclk) begin
        if (i_go) begin
            o_req_addr <= i_addr;
            o_req_io <= i_io;
            o_req_valid <= 1'b1;
        end else begin
            // Idle lines flip so a stale address never passes for a live one
            o_req_addr <= ~o_req_addr;
            o_req_io <= ~o_req_io;
            o_req_valid <= 1'b0;
        end
    end
endmodule : cfg_requester

// File: dv/test_func_cfg_bank.sv
// Self-checking testbench of the function configuration bank
`timescale 1ns/10ps
module test_func_cfg_bank;
    logic i_mclk;
    logic i_rst_n;
    logic [9:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic [31:0] req_addr;
    logic req_io;
    logic req_valid;
    logic o_req_hit;
    logic [1:0] o_req_pf;
    logic [2:0] o_req_bar;
    logic o_cfg_ok;
    logic o_map_busy;
    logic go;
    logic [31:0] go_addr;
    logic go_io;
    int fail_count;
    int check_count;
    // Entry: expected legality, word index, write data
    logic [42:0] tab [30] = '{
        {1'b1, 10'h0F0, 32'h0400}, {1'b0, 10'h024, 32'h0304},
        {1'b1, 10'h0F0, 32'h0401}, {1'b0, 10'h024, 32'h0303},
        {1'b0, 10'h0F0, 32'h0400}, {1'b0, 10'h024, 32'h0246},
        {1'b0, 10'h024, 32'h025F}, {1'b1, 10'h024, 32'h021F},
        {1'b0, 10'h024, 32'h0220}, {1'b1, 10'h024, 32'h02A0},
        {1'b1, 10'h024, 32'h020C}, {1'b0, 10'h030, 32'h0015},
        {1'b1, 10'h030, 32'h0041}, {1'b0, 10'h030, 32'h0043},
        {1'b1, 10'h030, 32'h0017}, {1'b1, 10'h0F0, 32'h0410},
        {1'b0, 10'h0F0, 32'h0510}, {1'b1, 10'h0F0, 32'h4010},
        {1'b1, 10'h011, 32'h00C0}, {1'b0, 10'h011, 32'h00C1},
        {1'b1, 10'h0F0, 32'h0410}, {1'b1, 10'h311, 32'h003B},
        {1'b0, 10'h111, 32'h0001}, {1'b1, 10'h111, 32'h0000},
        {1'b1, 10'h311, 32'h0000}, {1'b0, 10'h0F0, 32'h0400},
        {1'b1, 10'h011, 32'h0007}, {1'b0, 10'h011, 32'h0008},
        {1'b1, 10'h011, 32'h0007}, {1'b1, 10'h000, 32'h0000}
    };

    func_cfg_bank i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_req_addr(req_addr), .i_req_io(req_io),
        .i_req_valid(req_valid), .o_req_hit(o_req_hit), .o_req_pf(o_req_pf), .o_req_bar(o_req_bar),
        .o_cfg_ok(o_cfg_ok), .o_map_busy(o_map_busy));
    cfg_requester i_req (.i_mclk(i_mclk), .i_go(go), .i_addr(go_addr), .i_io(go_io),
        .o_req_addr(req_addr), .o_req_io(req_io), .o_req_valid(req_valid));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    task wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [9:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask : rd

    // Map rebuild is short; a stuck busy flag ends the run
    task idle;
        int n;
        n = 0;
        while (o_map_busy !== 1'b0 && n < 20) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        if (o_map_busy !== 1'b0) begin
            fail_count++;
            $display("[ERR] %0t map rebuild never finished", $time);
            conclude();
        end
        #1;
    endtask : idle

    // Expected value is {hit, pf, bar}; pf and bar only matter on a hit
    task probe(input logic [31:0] a, input logic io, input logic [5:0] exp);
        @(posedge i_mclk);
        go <= 1'b1;
        go_addr <= a;
        go_io <= io;
        @(posedge i_mclk);
        go <= 1'b0;
        #1;
        chk(32'({o_req_hit, o_req_hit ? {o_req_pf, o_req_bar} : 5'h00}), 32'(exp));
    endtask : probe

    initial begin
        i_rst_n = 1'b0;
        i_addr = 10'h000;
        i_wdata = 32'h00000000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        go = 1'b0;
        go_addr = 32'h00000000;
        go_io = 1'b0;
        fail_count = 0;
        check_count = 0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd(10'h000, 32'h00000000);
        wr(10'h300, 32'h00058000);
        rd(10'h300, 32'h00058000);
        wr(10'h210, 32'h00005C09);
        rd(10'h210, 32'h00005C09);
        rd(10'h010, 32'h00000000);
        wr(10'h020, 32'h0000020C);
        wr(10'h004, 32'hFFFFFFFF);
        rd(10'h004, 32'hFFFFF000);
        wr(10'h022, 32'h000002C7);
        wr(10'h006, 32'hFFFFFFFF);
        rd(10'h006, 32'hFFFFFF8C);
        wr(10'h004, 32'h80000000);
        probe(32'h80000010, 1'b0, 6'h20);
        probe(32'h80000010, 1'b1, 6'h00);
        probe(32'h80001000, 1'b0, 6'h00);
        wr(10'h023, 32'h0000020C);
        wr(10'h007, 32'h40000000);
        probe(32'h40000000, 1'b0, 6'h00);
        wr(10'h021, 32'h0000000C);
        wr(10'h005, 32'h20000000);
        probe(32'h00000000, 1'b0, 6'h00);
        wr(10'h120, 32'h0000020C);
        wr(10'h104, 32'h20000000);
        probe(32'h20000000, 1'b0, 6'h28);
        wr(10'h030, 32'h00000017);
        wr(10'h00C, 32'h30000000);
        probe(32'h30000400, 1'b0, 6'h26);
        for (int i = 0; i < 30; i++) begin
            wr(tab[i][41:32], tab[i][31:0]);
            idle();
            chk(32'(o_cfg_ok), 32'(tab[i][42]));
        end
        rd(10'h0F0, 32'h00000100);
        rd(10'h012, 32'h00000001);
        wr(10'h0F0, 32'h00000410);
        chk(32'(o_map_busy), 32'h1);
        wr(10'h011, 32'h00000009);
        idle();
        rd(10'h011, 32'h00000007);
        wr(10'h011, 32'h00000002);
        idle();
        wr(10'h111, 32'h00000003);
        idle();
        rd(10'h012, 32'h00000004);
        rd(10'h112, 32'h00000005);
        rd(10'h212, 32'h00000007);
        rd(10'h0F1, 32'h00000005);
        wr(10'h0E0, 32'h12345678);
        rd(10'h0E0, 32'h00000000);
        wr(10'h024, 32'h0000020C);
        wr(10'h008, 32'h90000000);
        probe(32'h90000000, 1'b0, 6'h24);
        wr(10'h0F0, 32'h00000403);
        idle();
        probe(32'h90000000, 1'b0, 6'h00);
        conclude();
    end
endmodule : test_func_cfg_bank
